// ===== common/hbs_cfg.svh
`ifndef HBS_CFG_SVH
`define HBS_CFG_SVH

// ==========================================
// configuration word
`define HBS_CFG_W 8
`define HBS_CFG_DEFAULT 8'h00
`define HBS_STRAP_MASK 8'hff

// ==========================================
// spi rom probe
`define HBS_SIG_ADDR 16'hfffa
`define HBS_SIG_B0 8'h32
`define HBS_SIG_B1 8'h44
`define HBS_SIG_B2 8'h46
`define HBS_SIG_B3 8'h55
`define HBS_SIG_LAST 2'h3
`define HBS_FETCH_ADDR 16'h0000

// ==========================================
// management bus register addresses
`define HBS_SOC_DATA_ADDR 8'h00
`define HBS_SOC_MASK_ADDR 8'h01
`define HBS_DONE_ADDR 8'hff

`endif

// ===== common/hbs_pkg.sv
package hbs_pkg;

	// ==========================================
	// boot stages
	typedef enum logic [3:0] {
		ST_STANDBY,
		ST_INIT,
		ST_PROBE,
		ST_CFG_RD,
		ST_STRAP,
		ST_SOC,
		ST_MERGE,
		ST_SUSPEND,
		ST_CHG,
		ST_CONNECT,
		ST_NORMAL
	} hbs_stage_t;

	// ==========================================
	// strap pins
	typedef struct packed {
		logic spi_boot;
		logic slave_config_setting;
		logic bc_en;
		logic spi_dual;
		logic spi_mode3;
		logic [7:0] cfg;
	} hbs_strap_t;

	// ==========================================
	// management bus write strobe
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} hbs_mgmt_wr_t;

endpackage

// ===== core/hbs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "hbs_cfg.svh"
// Overview of operation
// - reset pin low standby, high hub mode
// - standby disables ports, pins, pll, state
// - no configuration survives standby
// - release: reset, lock pll if refclk valid, load defaults
// - probe rom signature from fixed address
// - match enables external rom at zero
// - mismatch continues internal rom, default load
// - single/dual spi, modes zero and three
// - no spi strap skips rom probe
// - load defaults then strap overrides
// - latch straps, sample bus pins if slave
// - slave setting with both pull-ups enters soc stage
// - soc stage waits for changes until done write
// - merge defaults, soc and otp data
// - configured: idle, suspend without vbus
// - vbus goes charger detect or connect
// - connect on vbus, stay until removal
// - normal hub operation until mode change
// - otp via usb normal, bus soc stage
// - slave setting with both pull-ups puts bus in slave
module hbs_sequencer #(
	parameter int CFG_W = `HBS_CFG_W,
	parameter logic [`HBS_CFG_W-1:0] CFG_DEFAULT = `HBS_CFG_DEFAULT,
	parameter logic [`HBS_CFG_W-1:0] STRAP_MASK = `HBS_STRAP_MASK
) (
	// clocks and reset
	input wire logic mclk_i,
	input wire logic link_clk_i,
	input wire logic rst_i,
	// chip pins
	input wire logic chip_rst_n_i,
	input wire logic refclk_valid_i,
	input wire logic pll_locked_i,
	input wire hbs_pkg::hbs_strap_t strap_i,
	input wire logic mgmt_bus_data_pin_i,
	input wire logic mgmt_bus_clock_pin_i,
	input wire logic vbus_i,
	// spi rom byte reader
	output logic spi_rd_req_o,
	output logic [15:0] spi_addr_o,
	output logic spi_dual_o,
	output logic spi_mode3_o,
	input wire logic spi_byte_valid_i,
	input wire logic [7:0] spi_byte_i,
	output logic ext_rom_en_o,
	output logic [15:0] fetch_addr_o,
	// configuration sources and result
	input wire logic [CFG_W-1:0] otp_data_i,
	input wire logic [CFG_W-1:0] otp_mask_i,
	output logic [CFG_W-1:0] hub_cfg_o,
	output logic hub_cfg_valid_o,
	// hub control
	input wire logic chg_det_done_i,
	input wire logic host_configured_i,
	output var hbs_pkg::hbs_stage_t stage_o,
	output logic standby_o,
	output logic pll_run_o,
	output logic ports_en_o,
	output logic usb_pins_oe_o,
	output logic chg_det_run_o,
	output logic usb_connect_o,
	output logic otp_usb_grant_o,
	// management bus slave, link domain
	input wire hbs_pkg::hbs_mgmt_wr_t mgmt_wr_i,
	output logic mgmt_slave_o,
	output logic otp_mgmt_grant_o
);
	import hbs_pkg::*;

	localparam int SW = $bits(hbs_strap_t) + 7;

	// ==========================================
	// core domain synchronisers
	logic [SW-1:0] sync_a, sync_b;
	hbs_strap_t s_strap;
	logic s_rst_n, s_refclk, s_pll, s_sda, s_scl, s_vbus, s_done_tgl;
	logic done_q, done_evt, done_tgl;

	// two flops on every pin and on the link toggle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {strap_i, chip_rst_n_i, refclk_valid_i, pll_locked_i, mgmt_bus_data_pin_i,
				mgmt_bus_clock_pin_i, vbus_i, done_tgl};
			sync_b <= sync_a;
		end
	end

	assign {s_strap, s_rst_n, s_refclk, s_pll, s_sda, s_scl, s_vbus, s_done_tgl} = sync_b;

	// done toggle edge
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= s_done_tgl;
		end
	end

	assign done_evt = s_done_tgl ^ done_q;

	// ==========================================
	// stage sequencer
	hbs_stage_t next_stage;
	hbs_strap_t strap_q;
	logic [1:0] sig_idx;
	logic [7:0] sig_byte;
	logic sig_hit;
	logic [CFG_W-1:0] soc_data, soc_mask, soc_data_l, soc_mask_l;
	logic soc_open;

	// expected signature byte
	always_comb begin
		case (sig_idx)
			2'h0: sig_byte = `HBS_SIG_B0;
			2'h1: sig_byte = `HBS_SIG_B1;
			2'h2: sig_byte = `HBS_SIG_B2;
			default: sig_byte = `HBS_SIG_B3;
		endcase
	end

	assign sig_hit = spi_rd_req_o && spi_byte_valid_i && (spi_byte_i == sig_byte);

	// next stage
	always_comb begin
		next_stage = stage_o;
		case (stage_o)
			ST_STANDBY: next_stage = ST_INIT;
			ST_INIT: begin
				if (!s_refclk || s_pll) begin
					next_stage = s_strap.spi_boot ? ST_PROBE : ST_CFG_RD;
				end
			end
			ST_PROBE: begin
				if (spi_rd_req_o && spi_byte_valid_i) begin
					if (!sig_hit || sig_idx == `HBS_SIG_LAST) begin
						next_stage = ST_CFG_RD;
					end
				end
			end
			ST_CFG_RD: next_stage = ST_STRAP;
			ST_STRAP: begin
				if (s_strap.slave_config_setting && s_sda && s_scl) begin
					next_stage = ST_SOC;
				end else begin
					next_stage = ST_MERGE;
				end
			end
			ST_SOC: begin
				if (done_evt) begin
					next_stage = ST_MERGE;
				end
			end
			ST_MERGE: next_stage = ST_SUSPEND;
			ST_SUSPEND: begin
				if (s_vbus) begin
					next_stage = strap_q.bc_en ? ST_CHG : ST_CONNECT;
				end
			end
			ST_CHG: begin
				if (!s_vbus) begin
					next_stage = ST_SUSPEND;
				end else if (chg_det_done_i) begin
					next_stage = ST_CONNECT;
				end
			end
			ST_CONNECT: begin
				if (!s_vbus) begin
					next_stage = ST_SUSPEND;
				end else if (host_configured_i) begin
					next_stage = ST_NORMAL;
				end
			end
			ST_NORMAL: begin
				if (!s_vbus) begin
					next_stage = ST_SUSPEND;
				end
			end
			default: next_stage = ST_STANDBY;
		endcase
		if (!s_rst_n) begin
			next_stage = ST_STANDBY;
		end
	end

	// stage register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stage_o <= ST_STANDBY;
		end else begin
			stage_o <= next_stage;
		end
	end

	// signature probe requests
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sig_idx <= 2'h0;
			spi_rd_req_o <= 1'b0;
			spi_addr_o <= `HBS_SIG_ADDR;
		end else if (next_stage != ST_PROBE) begin
			sig_idx <= 2'h0;
			spi_rd_req_o <= 1'b0;
			spi_addr_o <= `HBS_SIG_ADDR;
		end else if (spi_rd_req_o && spi_byte_valid_i) begin
			sig_idx <= sig_idx + 2'h1;
			spi_rd_req_o <= 1'b0;
			spi_addr_o <= `HBS_SIG_ADDR + {14'h0, sig_idx} + 16'h1;
		end else begin
			spi_rd_req_o <= 1'b1;
		end
	end

	// rom selection and spi mode
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_rom_en_o <= 1'b0;
			fetch_addr_o <= `HBS_FETCH_ADDR;
			spi_dual_o <= 1'b0;
			spi_mode3_o <= 1'b0;
		end else if (next_stage == ST_STANDBY) begin
			ext_rom_en_o <= 1'b0;
			fetch_addr_o <= `HBS_FETCH_ADDR;
			spi_dual_o <= 1'b0;
			spi_mode3_o <= 1'b0;
		end else if (stage_o == ST_INIT) begin
			spi_dual_o <= s_strap.spi_dual;
			spi_mode3_o <= s_strap.spi_mode3;
		end else if (sig_hit && sig_idx == `HBS_SIG_LAST) begin
			ext_rom_en_o <= 1'b1;
			fetch_addr_o <= `HBS_FETCH_ADDR;
		end
	end

	// configuration word build up
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			hub_cfg_o <= CFG_DEFAULT;
			hub_cfg_valid_o <= 1'b0;
			strap_q <= '0;
			soc_data <= '0;
			soc_mask <= '0;
		end else begin
			case (stage_o)
				ST_STANDBY, ST_INIT: begin
					hub_cfg_o <= CFG_DEFAULT;
					hub_cfg_valid_o <= 1'b0;
					strap_q <= '0;
					soc_data <= '0;
					soc_mask <= '0;
				end
				ST_CFG_RD: hub_cfg_o <= (CFG_DEFAULT & ~STRAP_MASK) | (s_strap.cfg & STRAP_MASK);
				ST_STRAP: strap_q <= s_strap;
				ST_SOC: begin
					if (done_evt) begin
						soc_data <= soc_data_l; // stable: link locked after done
						soc_mask <= soc_mask_l;
					end
				end
				ST_MERGE: begin
					hub_cfg_o <= (((hub_cfg_o & ~soc_mask) | (soc_data & soc_mask)) & ~otp_mask_i)
						| (otp_data_i & otp_mask_i);
					hub_cfg_valid_o <= 1'b1;
				end
				default: hub_cfg_o <= hub_cfg_o;
			endcase
			// pin low: defaults at once, same edge as standby
			if (!s_rst_n) begin
				hub_cfg_o <= CFG_DEFAULT;
				hub_cfg_valid_o <= 1'b0;
			end
		end
	end

	// hub control outputs, aligned with the stage register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			standby_o <= 1'b1;
			pll_run_o <= 1'b0;
			ports_en_o <= 1'b0;
			usb_pins_oe_o <= 1'b0;
			chg_det_run_o <= 1'b0;
			usb_connect_o <= 1'b0;
			otp_usb_grant_o <= 1'b0;
			soc_open <= 1'b0;
		end else begin
			standby_o <= (next_stage == ST_STANDBY);
			pll_run_o <= (next_stage != ST_STANDBY);
			ports_en_o <= (next_stage == ST_CONNECT) || (next_stage == ST_NORMAL);
			usb_pins_oe_o <= (next_stage == ST_CONNECT) || (next_stage == ST_NORMAL);
			chg_det_run_o <= (next_stage == ST_CHG);
			usb_connect_o <= ((next_stage == ST_CONNECT) || (next_stage == ST_NORMAL)) && s_vbus;
			otp_usb_grant_o <= (next_stage == ST_NORMAL);
			soc_open <= (next_stage == ST_SOC);
		end
	end

	// ==========================================
	// link domain: management bus slave session
	logic lsync_a, lsync_b, locked;

	// soc stage level into link clock
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lsync_a <= 1'b0;
			lsync_b <= 1'b0;
		end else begin
			lsync_a <= soc_open;
			lsync_b <= lsync_a;
		end
	end

	// session writes and done toggle
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			locked <= 1'b0;
			done_tgl <= 1'b0;
			soc_data_l <= '0;
			soc_mask_l <= '0;
			otp_mgmt_grant_o <= 1'b0;
			mgmt_slave_o <= 1'b0;
		end else begin
			mgmt_slave_o <= lsync_b;
			otp_mgmt_grant_o <= lsync_b && !locked;
			if (!lsync_b) begin
				locked <= 1'b0;
				soc_data_l <= '0;
				soc_mask_l <= '0;
			end else if (mgmt_wr_i.valid && !locked) begin
				case (mgmt_wr_i.addr)
					`HBS_DONE_ADDR: begin
						locked <= 1'b1;
						done_tgl <= ~done_tgl;
					end
					`HBS_SOC_DATA_ADDR: soc_data_l <= mgmt_wr_i.data;
					`HBS_SOC_MASK_ADDR: soc_mask_l <= mgmt_wr_i.data;
					default: locked <= locked;
				endcase
			end
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_standby_follow: assert property (!s_rst_n |=> stage_o == ST_STANDBY && standby_o)
		else $error("reset pin low did not give standby");
	a_standby_quiet: assert property (standby_o |-> !ports_en_o && !usb_pins_oe_o && !pll_run_o && !ext_rom_en_o)
		else $error("standby left ports, pins or pll active");
	a_cfg_cleared: assert property (stage_o == ST_INIT |=> hub_cfg_o == CFG_DEFAULT && !hub_cfg_valid_o)
		else $error("configuration survived standby");
	a_release_init: assert property (stage_o == ST_STANDBY && s_rst_n |=> stage_o == ST_INIT)
		else $error("release did not restart at init");
	a_pll_wait: assert property (stage_o == ST_INIT && s_refclk && !s_pll && s_rst_n |=> stage_o == ST_INIT)
		else $error("left init before pll lock");
	a_probe_addr: assert property (spi_rd_req_o |-> spi_addr_o == `HBS_SIG_ADDR + {14'h0, sig_idx})
		else $error("probe address off signature window");
	a_rom_enable: assert property ($rose(ext_rom_en_o) |-> fetch_addr_o == `HBS_FETCH_ADDR
		&& $past(stage_o) == ST_PROBE && $past(sig_idx) == `HBS_SIG_LAST)
		else $error("external rom enabled without full signature");
	a_no_spi_skip: assert property (stage_o == ST_INIT && !s_strap.spi_boot |=> stage_o != ST_PROBE)
		else $error("probe entered without spi strap");
	a_soc_wait: assert property (stage_o == ST_SOC && !done_evt && s_rst_n |=> stage_o == ST_SOC)
		else $error("soc stage left without done write");
	a_vbus_bc: assert property (stage_o == ST_SUSPEND && s_vbus && strap_q.bc_en && s_rst_n
		|=> stage_o == ST_CHG && chg_det_run_o)
		else $error("vbus with charging did not start detection");
	a_connect_vbus: assert property (usb_connect_o |-> $past(s_vbus) && (stage_o == ST_CONNECT
		|| stage_o == ST_NORMAL))
		else $error("usb connect without vbus");
	a_otp_usb: assert property (otp_usb_grant_o |-> stage_o == ST_NORMAL)
		else $error("usb otp access outside normal");
	a_done_write: assert property (@(posedge link_clk_i) disable iff (rst_i)
		lsync_b && !locked && mgmt_wr_i.valid && mgmt_wr_i.addr == `HBS_DONE_ADDR
		|=> locked && done_tgl != $past(done_tgl) ##1 !otp_mgmt_grant_o)
		else $error("done write did not close session");

	c_rom_found: cover property ($rose(ext_rom_en_o));
	c_soc_path: cover property (stage_o == ST_SOC ##1 stage_o == ST_MERGE);
	c_chg_path: cover property (stage_o == ST_CHG ##1 stage_o == ST_CONNECT);
	c_normal: cover property (stage_o == ST_CONNECT ##1 stage_o == ST_NORMAL);
endmodule
`default_nettype wire

// ===== verification/hbs_rom_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// spi rom byte reader model, signature at top of 64k
module hbs_rom_model (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// byte request from the sequencer
	input wire logic req_i,
	input wire logic [15:0] addr_i,
	// scenario controls
	input wire logic bad_i,
	input wire logic [3:0] delay_i,
	// byte answer
	output logic valid_o,
	output logic [7:0] byte_o
);
	logic [3:0] cnt;

	// signature bytes, one corrupted on demand
	function automatic logic [7:0] rom_byte(input logic [15:0] a);
		case (a)
			16'hfffa: rom_byte = 8'h32;
			16'hfffb: rom_byte = 8'h44;
			16'hfffc: rom_byte = bad_i ? 8'h00 : 8'h46;
			16'hfffd: rom_byte = 8'h55;
			default: rom_byte = 8'hff;
		endcase
	endfunction

	// answer after delay_i idle cycles, one cycle pulse
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			byte_o <= 8'h00;
			cnt <= 4'h0;
		end else if (req_i && !valid_o && cnt == delay_i) begin
			valid_o <= 1'b1;
			byte_o <= rom_byte(addr_i);
			cnt <= 4'h0;
		end else begin
			valid_o <= 1'b0;
			byte_o <= ~byte_o; // data inverted each idle cycle
			cnt <= (req_i && !valid_o) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t: %s", $time, m); end end
module testbench;
	import hbs_pkg::*;
	// ==========================================
	// stimulus and observed signals
	logic mclk = 1'b0, link_clk = 1'b0, rst = 1'b1, chip_rst_n = 1'b0, pll_locked = 1'b0, vbus = 1'b0;
	logic pin_d = 1'b0, pin_c = 1'b0, chg_done = 1'b0, host_cfg = 1'b0, rom_bad = 1'b0, refclk = 1'b1;
	logic [3:0] rom_dly = 4'h0;
	hbs_strap_t strap = '0;
	hbs_mgmt_wr_t mgmt_wr = '0;
	logic req, valid, dual, mode3, ext_en, cfg_valid, stby, pll_run, ports_en, pins_oe;
	logic chg_run, connect, usb_grant, mgmt_slave, mgmt_grant;
	logic [7:0] rom_byte, hub_cfg;
	logic [15:0] spi_addr, fetch_addr;
	hbs_stage_t stage;
	logic [15:0] taken[$];
	int error_cnt = 0, cmp_count = 0;

	// ==========================================
	// clocks, link clock offset in phase
	always #25 mclk = ~mclk;
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end

	hbs_sequencer dut_u (.mclk_i(mclk), .link_clk_i(link_clk), .rst_i(rst), .chip_rst_n_i(chip_rst_n),
		.refclk_valid_i(refclk), .pll_locked_i(pll_locked), .strap_i(strap), .mgmt_bus_data_pin_i(pin_d),
		.mgmt_bus_clock_pin_i(pin_c), .vbus_i(vbus), .spi_rd_req_o(req), .spi_addr_o(spi_addr),
		.spi_dual_o(dual), .spi_mode3_o(mode3), .spi_byte_valid_i(valid), .spi_byte_i(rom_byte),
		.ext_rom_en_o(ext_en), .fetch_addr_o(fetch_addr), .otp_data_i(8'hff), .otp_mask_i(8'h81),
		.hub_cfg_o(hub_cfg), .hub_cfg_valid_o(cfg_valid), .chg_det_done_i(chg_done),
		.host_configured_i(host_cfg), .stage_o(stage), .standby_o(stby), .pll_run_o(pll_run),
		.ports_en_o(ports_en), .usb_pins_oe_o(pins_oe), .chg_det_run_o(chg_run), .usb_connect_o(connect),
		.otp_usb_grant_o(usb_grant), .mgmt_wr_i(mgmt_wr), .mgmt_slave_o(mgmt_slave),
		.otp_mgmt_grant_o(mgmt_grant));

	hbs_rom_model rom_u (.mclk_i(mclk), .rst_i(rst), .req_i(req), .addr_i(spi_addr), .bad_i(rom_bad),
		.delay_i(rom_dly), .valid_o(valid), .byte_o(rom_byte));

	// log of every rom byte taken by the sequencer
	always @(posedge mclk) if (req === 1'b1 && valid === 1'b1) taken.push_back(spi_addr);

	// ==========================================
	// shared tasks
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wait_stage(input hbs_stage_t s, input int n);
		for (int i = 0; i < n && stage !== s; i++) @(posedge mclk) #1;
		`CHK(stage, s, "stage not reached")
	endtask

	task automatic mgmt_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge link_clk) mgmt_wr <= '{1'b1, a, d};
		@(posedge link_clk) mgmt_wr.valid <= 1'b0;
	endtask

	// chip reset pulse, standby checks, release with new straps
	task automatic restart(input logic sb, sl, bc, input logic [1:0] dm);
		@(posedge mclk) chip_rst_n <= 1'b0;
		pll_locked <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 `CHK(stage, ST_STANDBY, "no standby")
		`CHK({stby, ports_en, pins_oe, pll_run, ext_en}, 5'h10, "standby outputs")
		`CHK({cfg_valid, hub_cfg}, 9'h000, "config kept")
		taken.delete();
		@(posedge mclk) strap <= '{sb, sl, bc, dm[1], dm[0], 8'h3c};
		chip_rst_n <= 1'b1;
		wait_stage(ST_INIT, 8);
		repeat (4) @(posedge mclk);
		#1 `CHK(stage == ST_INIT, refclk, "pll lock wait wrong")
		@(posedge mclk) pll_locked <= 1'b1;
	endtask

	// ==========================================
	// scenarios
	task automatic boot_rom(input logic [3:0] dly, input logic bad, input logic [1:0] dm);
		rom_dly = dly;
		rom_bad = bad;
		restart(1'b1, 1'b0, 1'b0, dm);
		wait_stage(ST_CFG_RD, 200);
		`CHK(taken.size(), bad ? 3 : 4, "probe byte count")
		`CHK(taken[taken.size() - 1], bad ? 16'hfffc : 16'hfffd, "probe order")
		`CHK(ext_en, !bad, "rom enable")
		`CHK(fetch_addr, 16'h0000, "fetch start")
		`CHK({dual, mode3}, dm, "spi mode")
		wait_stage(ST_SUSPEND, 50);
		`CHK({cfg_valid, hub_cfg}, 9'h1bd, "merged cfg")
		$display("test boot_rom done");
	endtask

	// no reference clock here: init must go on without pll lock
	task automatic boot_plain();
		@(posedge mclk) pin_d <= 1'b1;
		refclk <= 1'b0;
		restart(1'b0, 1'b1, 1'b1, 2'b00);
		wait_stage(ST_SUSPEND, 60);
		`CHK(taken.size(), 0, "probe not skipped")
		`CHK({mgmt_slave, ext_en, hub_cfg}, 10'h0bd, "one pull-up only")
		@(posedge mclk) pin_d <= 1'b0;
		refclk <= 1'b1;
		$display("test boot_plain done");
	endtask

	task automatic boot_soc();
		@(posedge mclk) pin_d <= 1'b1;
		pin_c <= 1'b1;
		restart(1'b0, 1'b1, 1'b0, 2'b11);
		wait_stage(ST_SOC, 60);
		repeat (40) @(posedge mclk);
		#1 `CHK(stage, ST_SOC, "soc stage left")
		`CHK({mgmt_slave, mgmt_grant, usb_grant}, 3'b110, "soc session")
		mgmt_write(8'h00, 8'ha5);
		mgmt_write(8'h01, 8'h0f);
		repeat (6) @(posedge mclk);
		#1 `CHK(stage, ST_SOC, "left before done")
		mgmt_write(8'hff, 8'h00);
		wait_stage(ST_SUSPEND, 30);
		mgmt_write(8'h00, 8'h00);
		repeat (4) @(posedge mclk);
		#1 `CHK({cfg_valid, hub_cfg}, 9'h1b5, "soc merge")
		`CHK({mgmt_slave, mgmt_grant}, 2'b00, "session kept")
		@(posedge mclk) pin_d <= 1'b0;
		pin_c <= 1'b0;
		$display("test boot_soc done");
	endtask

	task automatic vbus_flow(input logic bc);
		@(posedge mclk) vbus <= 1'b1;
		if (bc) begin
			wait_stage(ST_CHG, 10);
			`CHK({chg_run, connect, ports_en}, 3'b100, "charger detect")
			@(posedge mclk) chg_done <= 1'b1;
			@(posedge mclk) chg_done <= 1'b0;
		end
		wait_stage(ST_CONNECT, 10);
		`CHK({connect, ports_en, pins_oe, usb_grant}, 4'he, "connect")
		@(posedge mclk) host_cfg <= 1'b1;
		wait_stage(ST_NORMAL, 10);
		`CHK({usb_grant, mgmt_grant}, 2'b10, "otp over usb")
		@(posedge mclk) vbus <= 1'b0;
		host_cfg <= 1'b0;
		wait_stage(ST_SUSPEND, 10);
		`CHK({connect, ports_en}, 2'b00, "suspend outputs")
		$display("test vbus_flow done");
	endtask

	// ==========================================
	// main sequence and watchdog
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		boot_rom(4'h0, 1'b0, 2'b10);
		vbus_flow(1'b0);
		boot_rom(4'h3, 1'b1, 2'b01);
		boot_plain();
		vbus_flow(1'b1);
		boot_soc();
		vbus_flow(1'b0);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("mismatch at %0t: watchdog", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
